//--- rtl/asp_params.svh
// Constants of the angle signal path: offsets, fields, resets, timing
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH
// ==========================================================
// Timing
`define ASP_CLK_NS       20
`define ASP_SAMPLE_NS    125000
`define ASP_LAT_MAX      128
// ==========================================================
// Arithmetic shifts (32768 = 2**15)
`define ASP_AMP_SH       15
`define ASP_PH_SH        15
`define ASP_TC_SH        15
`define ASP_CG_SH        14
`define ASP_SG_SH        12
`define ASP_OG_SH        12
`define ASP_DNC_SH       8
`define ASP_CORDIC_N     14
`define ASP_FIX_SH       11
// ==========================================================
// Observation registers (word index), read-only except FB, write one to clear
`define ASP_R_TEMP       8'h00
`define ASP_R_CA         8'h01
`define ASP_R_CB         8'h02
`define ASP_R_AMP        8'h03
`define ASP_R_UA         8'h04
`define ASP_R_UB         8'h05
`define ASP_R_PB         8'h06
`define ASP_R_ANG        8'h07
`define ASP_R_REF        8'h08
`define ASP_R_MOD        8'h09
`define ASP_R_SPIN       8'h0a
`define ASP_R_SPOUT      8'h0b
`define ASP_R_DNC        8'h0c
`define ASP_R_SCALE      8'h0d
`define ASP_R_OUT        8'h0e
`define ASP_R_FA         8'h0f
`define ASP_R_FB         8'h10
`define ASP_R_IDA        8'h11
`define ASP_R_IDB        8'h12
// ==========================================================
// Configuration registers
`define ASP_R_PHASE      8'h18
`define ASP_R_GAIN_A     8'h19
`define ASP_R_GAIN_B     8'h1a
`define ASP_R_OFF_A      8'h1b
`define ASP_R_OFF_B      8'h1c
`define ASP_R_REFANG     8'h1d
`define ASP_R_MODSH      8'h1e
`define ASP_R_SPGAIN     8'h1f
`define ASP_R_SPOFF      8'h20
`define ASP_R_SETUP      8'h21
`define ASP_R_DNCCFG     8'h22
`define ASP_R_OGAIN      8'h23
`define ASP_R_OOFF       8'h24
`define ASP_R_MAGLO      8'h25
`define ASP_R_MAGHI      8'h26
`define ASP_R_TC         8'h27
`define ASP_R_SPX        8'h30
`define ASP_R_SPY        8'h48
// ==========================================================
// Fields and reset values
`define ASP_SETUP_VAR    0
`define ASP_SETUP_SLOW   1
`define ASP_FB_TEST      0
`define ASP_FB_OVR       1
`define ASP_FB_CLIP      2
`define ASP_GAIN_RST     16'h4000
`define ASP_UNITY12      16'h1000
`define ASP_MAGHI_RST    16'hffff
`define ASP_TEST_IN      20'sh04000
`define ASP_TEST_ANG     16'h2000
`define ASP_TEST_TOL     16'h0010
`endif

//--- rtl/asp_pkg.sv
// Types of the angle signal path
package asp_pkg;
  typedef enum logic [3:0] {
    ASP_TEST, ASP_IDLE, ASP_CORR, ASP_PHASE, ASP_USER, ASP_ANGLE,
    ASP_POST, ASP_SEEK, ASP_DIV, ASP_FILT, ASP_OUT, ASP_COMMIT
  } asp_state_e;
  typedef struct packed {
    asp_state_e st; logic test; logic [5:0] cnt; logic [5:0] k;
    logic signed [15:0] sa, sb, tmp, ca, cb, ua, ub, pb;
    logic [16:0] amp;
    logic signed [19:0] cx, cy; logic [15:0] cz;
    logic [15:0] ang, refa, modo; logic signed [15:0] spin, dnc;
    logic signed [15:0] y0; logic neg;
    logic [33:0] num, quo; logic [16:0] den; logic [17:0] rem;
    logic [15:0] o_temp, o_ca, o_cb, o_ua, o_ub, o_pb, o_ang, o_ref;
    logic [15:0] o_mod, o_spin, o_spout, o_dnc, o_scl, o_out;
    logic [16:0] o_amp; logic [15:0] diag_a, diag_b;
    logic signed [15:0] phase, gain_a, gain_b, off_a, off_b, spgain;
    logic signed [15:0] spoff, ogain, ooff, tc;
    logic [15:0] refang, dncr, maglo, maghi; logic [2:0] modsh;
    logic [1:0] setup;
    logic [16:0][15:0] sp_x; logic [32:0][15:0] sp_y;
    logic [11:0] code; logic ovalid, magf;
    logic [15:0] sw; logic swv, ssel; logic [31:0] rdata;
  } asp_state_s;
endpackage

//--- rtl/asp_top.sv
// Angle signal path: compensation, angle, setpoints, filter, readback
// Notes on behaviour
// - Amplitude is ch_a squared over 32768 plus ch_b squared over 32768.
// - Amplitude drives the magnet loss check.
// - Temperature compensated channel values are readable per channel.
// - Phase, gain and offset corrected channels feed the angle and are readable.
// - Channel b after interchannel phase correction is readable on its own.
// - Angle computed from corrected channels, raw angle readable.
// - Reference angle subtracted to move zero, result readable.
// - Shifted angle wrapped by modulo, result readable.
// - Wrapped angle scaled by setpoint gain and offset, readable.
// - Linearized angle readable.
// - Noise cancellation filter output readable.
// - Output gain and offset applied, result readable.
// - Final output register holds fully processed position.
// - Power-up self test and runtime checks recorded in two fault registers.
// - Two read-only 16-bit id words sent on slow channel when enabled.
// - Junction temperature readable as sampled, without compensation.
// - Observation registers read-only except FB (write one to clear), configuration registers steer processing.
// - Path keeps up with 8 kSps sample rate.
// - Final value drives a 12-bit output.
// - Linearization uses 17 variable or 33 fixed setpoints by configuration.
// - Linear interpolation between the two bracketing setpoints.
// - Amplitude compared to low and high limits, error when exceeded.
//
// The address-and-strobe port and the address map were left to the implementer.
`include "asp_params.svh"
module asp_top #(
  parameter int          SAMPLE_CYC = `ASP_SAMPLE_NS / `ASP_CLK_NS,
  parameter logic [15:0] ID_A       = 16'h1111, // Arbitrary value
  parameter logic [15:0] ID_B       = 16'h2222  // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_ch_a,
  input  wire logic [15:0] sample_ch_b,
  input  wire logic [15:0] junction_temp_in,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic      [11:0] out_code,
  output logic             out_valid,
  output logic             mag_fault,
  output logic      [15:0] slow_word,
  output logic             slow_valid,
  input  wire logic        slow_take
);
  import asp_pkg::*;

  // =========================================================
  // Elaboration checks
  if (SAMPLE_CYC < `ASP_LAT_MAX) begin : g_chk
    $error("SAMPLE_CYC shorter than worst path latency");
  end

  // =========================================================
  // Helpers
  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sh00007fff) return 16'sh7fff;
    if (v < -32'sh00008000) return 16'sh8000;
    return v[15:0];
  endfunction

  function automatic logic [15:0] atan_lut(input logic [3:0] i);
    unique case (i)
      4'h0: return 16'h2000;
      4'h1: return 16'h12e4;
      4'h2: return 16'h09fb;
      4'h3: return 16'h0511;
      4'h4: return 16'h028b;
      4'h5: return 16'h0146;
      4'h6: return 16'h00a3;
      4'h7: return 16'h0051;
      4'h8: return 16'h0029;
      4'h9: return 16'h0014;
      4'ha: return 16'h000a;
      4'hb: return 16'h0005;
      4'hc: return 16'h0003;
      default: return 16'h0001;
    endcase
  endfunction

  // Fixed grid spans 2048 LSB; the top point clips to 32767
  function automatic logic signed [16:0] xpos(input logic vm, input logic [5:0] k,
                                              input logic [16:0][15:0] xr);
    if (k == 6'h00) return -17'sh08000;
    if (k >= (vm ? 6'h12 : 6'h20)) return 17'sh07fff;
    if (vm) return {xr[k - 6'h01][15], xr[k - 6'h01]};
    return -17'sh08000 + 17'($unsigned(k) << `ASP_FIX_SH);
  endfunction

  // =========================================================
  // State
  asp_state_s q_r, q_nxt;

  always_comb begin
    logic signed [31:0] p0;
    logic signed [31:0] p1;
    logic signed [19:0] dx;
    logic signed [19:0] dy;
    logic signed [16:0] x0;
    logic signed [16:0] x1;
    logic signed [16:0] d0;
    logic signed [16:0] d1;
    logic signed [33:0] pr;
    logic [17:0] r;
    logic [15:0] md;
    logic signed [16:0] lin;
    logic [5:0] last;
    p0 = '0;
    p1 = '0;
    dx = '0;
    dy = '0;
    x0 = '0;
    x1 = '0;
    d0 = '0;
    d1 = '0;
    pr = '0;
    r = '0;
    md = '0;
    lin = '0;
    last = q_r.setup[`ASP_SETUP_VAR] ? 6'h12 : 6'h20;
    q_nxt = q_r;
    q_nxt.ovalid = 1'b0;
    q_nxt.rdata = '0;
    // Clear before the fault sources below, so a fault raised in the clear cycle still lands
    if (reg_wr && reg_addr == `ASP_R_FB)
      q_nxt.diag_b = q_r.diag_b & ~reg_wdata[15:0];

    // =======================================================
    // Datapath sequencer
    unique case (q_r.st)
      ASP_TEST: begin
        q_nxt.cx = `ASP_TEST_IN;
        q_nxt.cy = `ASP_TEST_IN;
        q_nxt.cz = '0;
        q_nxt.cnt = '0;
        q_nxt.test = 1'b1;
        q_nxt.st = ASP_ANGLE;
      end
      ASP_IDLE: begin
        if (sample_valid) begin
          q_nxt.sa = sample_ch_a;
          q_nxt.sb = sample_ch_b;
          q_nxt.tmp = junction_temp_in;
          q_nxt.st = ASP_CORR;
          if (sample_ch_a == 16'h8000 || sample_ch_b == 16'h8000)
            q_nxt.diag_b[`ASP_FB_CLIP] = 1'b1;
        end
      end
      ASP_CORR: begin
        p0 = q_r.tmp * q_r.tc;
        q_nxt.ca = sat16(32'(q_r.sa) + (p0 >>> `ASP_TC_SH));
        q_nxt.cb = sat16(32'(q_r.sb) + (p0 >>> `ASP_TC_SH));
        q_nxt.st = ASP_PHASE;
      end
      ASP_PHASE: begin
        p0 = q_r.ca * q_r.ca;
        p1 = q_r.cb * q_r.cb;
        q_nxt.amp = p0[31:`ASP_AMP_SH] + p1[31:`ASP_AMP_SH];
        p0 = q_r.ca * q_r.phase;
        q_nxt.pb = sat16(32'(q_r.cb) - (p0 >>> `ASP_PH_SH));
        p1 = q_r.ca * q_r.gain_a;
        q_nxt.ua = sat16((p1 >>> `ASP_CG_SH) + 32'(q_r.off_a));
        q_nxt.st = ASP_USER;
      end
      ASP_USER: begin
        p0 = q_r.pb * q_r.gain_b;
        q_nxt.ub = sat16((p0 >>> `ASP_CG_SH) + 32'(q_r.off_b));
        q_nxt.cx = 20'(q_r.ua);
        q_nxt.cy = 20'(q_nxt.ub);
        q_nxt.cz = '0;
        q_nxt.cnt = '0;
        q_nxt.test = 1'b0;
        q_nxt.st = ASP_ANGLE;
      end
      ASP_ANGLE: begin
        // Left half plane folded first so the rotations converge
        if (q_r.cnt == 6'h00 && q_r.cx < 0) begin
          q_nxt.cx = -q_r.cx;
          q_nxt.cy = -q_r.cy;
          q_nxt.cz = 16'h8000;
          q_nxt.cnt = 6'h01;
        end else begin
          dx = q_r.cy >>> (q_r.cnt[3:0] - 4'h1);
          dy = q_r.cx >>> (q_r.cnt[3:0] - 4'h1);
          if (q_r.cnt == 6'h00) begin
            q_nxt.cnt = 6'h01;
          end else if (!q_r.cy[19]) begin
            q_nxt.cx = q_r.cx + dx;
            q_nxt.cy = q_r.cy - dy;
            q_nxt.cz = q_r.cz + atan_lut(q_r.cnt[3:0] - 4'h1);
            q_nxt.cnt = q_r.cnt + 6'h01;
          end else begin
            q_nxt.cx = q_r.cx - dx;
            q_nxt.cy = q_r.cy + dy;
            q_nxt.cz = q_r.cz - atan_lut(q_r.cnt[3:0] - 4'h1);
            q_nxt.cnt = q_r.cnt + 6'h01;
          end
          if (q_r.cnt == 6'(`ASP_CORDIC_N)) begin
            q_nxt.ang = q_r.cz;
            q_nxt.st = q_r.test ? ASP_IDLE : ASP_POST;
            md = q_r.cz - `ASP_TEST_ANG;
            if (q_r.test && md > `ASP_TEST_TOL && md < -`ASP_TEST_TOL)
              q_nxt.diag_b[`ASP_FB_TEST] = 1'b1;
          end
        end
      end
      ASP_POST: begin
        md = q_r.ang - q_r.refang;
        q_nxt.refa = md;
        md = md << q_r.modsh;
        q_nxt.modo = md;
        p0 = $signed(md ^ 16'h8000) * q_r.spgain;
        q_nxt.spin = sat16((p0 >>> `ASP_SG_SH) + 32'(q_r.spoff));
        q_nxt.k = '0;
        q_nxt.st = ASP_SEEK;
      end
      ASP_SEEK: begin
        x0 = xpos(q_r.setup[`ASP_SETUP_VAR], q_r.k, q_r.sp_x);
        x1 = xpos(q_r.setup[`ASP_SETUP_VAR], q_r.k + 6'h01, q_r.sp_x);
        if (17'(q_r.spin) < x1 || q_r.k + 6'h01 >= last) begin
          d0 = 17'($signed(q_r.sp_y[q_r.k + 6'h01])) - 17'($signed(q_r.sp_y[q_r.k]));
          d1 = 17'(q_r.spin) - x0;
          pr = d0 * d1;
          q_nxt.y0 = q_r.sp_y[q_r.k];
          q_nxt.neg = pr[33];
          q_nxt.num = pr[33] ? 34'(-pr) : 34'(pr);
          q_nxt.den = 17'(x1 - x0);
          q_nxt.rem = '0;
          q_nxt.quo = '0;
          q_nxt.cnt = '0;
          // Unsorted variable points give no slope, hold the left value
          q_nxt.st = (x1 > x0) ? ASP_DIV : ASP_FILT;
        end else begin
          q_nxt.k = q_r.k + 6'h01;
        end
      end
      ASP_DIV: begin
        r = {q_r.rem[16:0], q_r.num[33]};
        q_nxt.num = {q_r.num[32:0], 1'b0};
        if (r >= {1'b0, q_r.den}) begin
          q_nxt.rem = r - {1'b0, q_r.den};
          q_nxt.quo = {q_r.quo[32:0], 1'b1};
        end else begin
          q_nxt.rem = r;
          q_nxt.quo = {q_r.quo[32:0], 1'b0};
        end
        q_nxt.cnt = q_r.cnt + 6'h01;
        if (q_r.cnt == 6'd33) q_nxt.st = ASP_FILT;
      end
      ASP_FILT: begin
        p0 = 32'(q_r.y0) + (q_r.neg ? -32'(q_r.quo[16:0]) : 32'(q_r.quo[16:0]));
        q_nxt.o_spout = sat16(p0);
        lin = 17'(sat16(p0)) - 17'(q_r.dnc);
        d1 = lin[16] ? -lin : lin;
        // Large steps bypass the slow filter so real motion is not lagged
        if (q_r.dncr == 16'h0000 || d1 >= 17'({q_r.dncr[15:8], 4'h0})) begin
          q_nxt.dnc = sat16(p0);
        end else begin
          p1 = 32'(lin) * 32'(q_r.dncr[7:0]);
          q_nxt.dnc = sat16(32'(q_r.dnc) + (p1 >>> `ASP_DNC_SH));
        end
        q_nxt.st = ASP_OUT;
      end
      ASP_OUT: begin
        p0 = q_r.dnc * q_r.ogain;
        q_nxt.o_scl = sat16((p0 >>> `ASP_OG_SH) + 32'(q_r.ooff));
        q_nxt.st = ASP_COMMIT;
      end
      ASP_COMMIT: begin
        // Stage results except o_spout and o_scl land in one edge
        q_nxt.o_temp = q_r.tmp;
        q_nxt.o_ca = q_r.ca;
        q_nxt.o_cb = q_r.cb;
        q_nxt.o_amp = q_r.amp;
        q_nxt.o_ua = q_r.ua;
        q_nxt.o_ub = q_r.ub;
        q_nxt.o_pb = q_r.pb;
        q_nxt.o_ang = q_r.ang;
        q_nxt.o_ref = q_r.refa;
        q_nxt.o_mod = q_r.modo;
        q_nxt.o_spin = q_r.spin;
        q_nxt.o_dnc = q_r.dnc;
        q_nxt.o_out = q_r.o_scl ^ 16'h8000;
        q_nxt.code = q_nxt.o_out[15:4];
        q_nxt.ovalid = 1'b1;
        q_nxt.diag_a = {14'h0000, q_r.amp > {1'b0, q_r.maghi},
                        q_r.amp < {1'b0, q_r.maglo}};
        q_nxt.magf = q_r.amp > {1'b0, q_r.maghi} ||
                     q_r.amp < {1'b0, q_r.maglo};
        q_nxt.st = ASP_IDLE;
      end
    endcase
    if (sample_valid && q_r.st != ASP_IDLE && q_r.st != ASP_TEST)
      q_nxt.diag_b[`ASP_FB_OVR] = 1'b1;

    // =======================================================
    // Slow channel id feed
    if (q_r.swv && slow_take) begin
      q_nxt.swv = 1'b0;
      q_nxt.ssel = ~q_r.ssel;
    end else if (!q_r.swv && q_r.setup[`ASP_SETUP_SLOW]) begin
      q_nxt.sw = q_r.ssel ? ID_B : ID_A;
      q_nxt.swv = 1'b1;
    end

    // =======================================================
    // Register port; observation words ignore writes, except FB, where written ones clear bits
    if (reg_wr) begin
      unique case (reg_addr)
        `ASP_R_PHASE: q_nxt.phase = reg_wdata[15:0];
        `ASP_R_GAIN_A: q_nxt.gain_a = reg_wdata[15:0];
        `ASP_R_GAIN_B: q_nxt.gain_b = reg_wdata[15:0];
        `ASP_R_OFF_A: q_nxt.off_a = reg_wdata[15:0];
        `ASP_R_OFF_B: q_nxt.off_b = reg_wdata[15:0];
        `ASP_R_REFANG: q_nxt.refang = reg_wdata[15:0];
        `ASP_R_MODSH: q_nxt.modsh = reg_wdata[2:0];
        `ASP_R_SPGAIN: q_nxt.spgain = reg_wdata[15:0];
        `ASP_R_SPOFF: q_nxt.spoff = reg_wdata[15:0];
        `ASP_R_SETUP: q_nxt.setup = reg_wdata[1:0];
        `ASP_R_DNCCFG: q_nxt.dncr = reg_wdata[15:0];
        `ASP_R_OGAIN: q_nxt.ogain = reg_wdata[15:0];
        `ASP_R_OOFF: q_nxt.ooff = reg_wdata[15:0];
        `ASP_R_MAGLO: q_nxt.maglo = reg_wdata[15:0];
        `ASP_R_MAGHI: q_nxt.maghi = reg_wdata[15:0];
        `ASP_R_TC: q_nxt.tc = reg_wdata[15:0];
        default: begin
          if (reg_addr >= `ASP_R_SPX && reg_addr < `ASP_R_SPX + 8'd17)
            q_nxt.sp_x[5'(reg_addr - `ASP_R_SPX)] = reg_wdata[15:0];
          if (reg_addr >= `ASP_R_SPY && reg_addr < `ASP_R_SPY + 8'd33)
            q_nxt.sp_y[6'(reg_addr - `ASP_R_SPY)] = reg_wdata[15:0];
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `ASP_R_TEMP: q_nxt.rdata[15:0] = q_r.o_temp;
        `ASP_R_CA: q_nxt.rdata[15:0] = q_r.o_ca;
        `ASP_R_CB: q_nxt.rdata[15:0] = q_r.o_cb;
        `ASP_R_AMP: q_nxt.rdata[16:0] = q_r.o_amp;
        `ASP_R_UA: q_nxt.rdata[15:0] = q_r.o_ua;
        `ASP_R_UB: q_nxt.rdata[15:0] = q_r.o_ub;
        `ASP_R_PB: q_nxt.rdata[15:0] = q_r.o_pb;
        `ASP_R_ANG: q_nxt.rdata[15:0] = q_r.o_ang;
        `ASP_R_REF: q_nxt.rdata[15:0] = q_r.o_ref;
        `ASP_R_MOD: q_nxt.rdata[15:0] = q_r.o_mod;
        `ASP_R_SPIN: q_nxt.rdata[15:0] = q_r.o_spin;
        `ASP_R_SPOUT: q_nxt.rdata[15:0] = q_r.o_spout;
        `ASP_R_DNC: q_nxt.rdata[15:0] = q_r.o_dnc;
        `ASP_R_SCALE: q_nxt.rdata[15:0] = q_r.o_scl;
        `ASP_R_OUT: q_nxt.rdata[15:0] = q_r.o_out;
        `ASP_R_FA: q_nxt.rdata[15:0] = q_r.diag_a;
        `ASP_R_FB: q_nxt.rdata[15:0] = q_r.diag_b;
        `ASP_R_IDA: q_nxt.rdata[15:0] = ID_A;
        `ASP_R_IDB: q_nxt.rdata[15:0] = ID_B;
        `ASP_R_PHASE: q_nxt.rdata[15:0] = q_r.phase;
        `ASP_R_REFANG: q_nxt.rdata[15:0] = q_r.refang;
        `ASP_R_SETUP: q_nxt.rdata[1:0] = q_r.setup;
        `ASP_R_DNCCFG: q_nxt.rdata[15:0] = q_r.dncr;
        `ASP_R_MAGLO: q_nxt.rdata[15:0] = q_r.maglo;
        `ASP_R_MAGHI: q_nxt.rdata[15:0] = q_r.maghi;
        default: q_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q_r <= '0;
      q_r.st <= ASP_TEST;
      q_r.gain_a <= `ASP_GAIN_RST;
      q_r.gain_b <= `ASP_GAIN_RST;
      q_r.spgain <= `ASP_UNITY12;
      q_r.ogain <= `ASP_UNITY12;
      q_r.maghi <= `ASP_MAGHI_RST;
    end else if (clk_en) begin
      q_r <= q_nxt;
    end
  end

  assign reg_rdata = q_r.rdata;
  assign out_code = q_r.code;
  assign out_valid = q_r.ovalid;
  assign mag_fault = q_r.magf;
  assign slow_word = q_r.sw;
  assign slow_valid = q_r.swv;

  // =========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !clk_en);

  amp_sum_a: assert property (out_valid |-> q_r.o_amp == 17'(
    ((32'($signed(q_r.o_ca)) * 32'($signed(q_r.o_ca))) >> `ASP_AMP_SH) +
    ((32'($signed(q_r.o_cb)) * 32'($signed(q_r.o_cb))) >> `ASP_AMP_SH)))
    else $error("amplitude not sum of squares");
  mag_flag_a: assert property (out_valid |-> mag_fault ==
    (q_r.o_amp < {1'b0, q_r.maglo} || q_r.o_amp > {1'b0, q_r.maghi}))
    else $error("magnet range flag wrong");
  out_code_a: assert property (out_valid |-> out_code == q_r.o_out[15:4])
    else $error("output code not top of final value");
  ref_shift_a: assert property (out_valid |-> q_r.o_ref == q_r.o_ang - q_r.refang)
    else $error("reference shift wrong");
  mod_wrap_a: assert property (out_valid |->
    q_r.o_mod == 16'(q_r.o_ref << q_r.modsh))
    else $error("wrap wrong");
  path_latency_a: assert property ($rose(q_r.st == ASP_CORR) |->
    ##[1:127] out_valid) else $error("sample not finished in time");
  ro_write_a: assert property (reg_wr && reg_addr == `ASP_R_OUT &&
    q_r.st != ASP_COMMIT |=> $stable(q_r.o_out)) else $error("observation written");
  read_ang_a: assert property (reg_rd && reg_addr == `ASP_R_ANG &&
    q_r.st != ASP_COMMIT |=> reg_rdata == {16'h0000, q_r.o_ang})
    else $error("angle readback wrong");
  fault_sticky_a: assert property (q_r.diag_b[`ASP_FB_OVR] &&
    !(reg_wr && reg_addr == `ASP_R_FB) |=> q_r.diag_b[`ASP_FB_OVR])
    else $error("fault bit dropped");
  slow_id_a: assert property (slow_valid |->
    slow_word == (q_r.ssel ? ID_B : ID_A)) else $error("slow word wrong");
  self_test_a: assert property (q_r.st == ASP_TEST |-> ##[1:20]
    q_r.st == ASP_IDLE) else $error("self test hung");

  sample_done_c: cover property (out_valid);
  var_mode_c: cover property (out_valid && q_r.setup[`ASP_SETUP_VAR]);
  slow_take_c: cover property (slow_valid && slow_take);
  mag_err_c: cover property (out_valid && mag_fault);
endmodule // asp_top

//--- test/asp_adc_model.sv
// Converter model: one sample pulse per request from the bench
module asp_adc_model (
  input  wire logic        clk,
  input  wire logic        fire,
  input  wire logic [15:0] val_a,
  input  wire logic [15:0] val_b,
  input  wire logic [15:0] val_t,
  output logic             sample_valid,
  output logic      [15:0] sample_ch_a,
  output logic      [15:0] sample_ch_b,
  output logic      [15:0] junction_temp_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sample_valid = 1'b0;
    sample_ch_a = 16'h0000;
    sample_ch_b = 16'h0000;
    junction_temp_in = 16'h0000;
  end
  // Outside the pulse the lines toggle, so a stale capture cannot pass
  always @(posedge clk) begin
    sample_valid <= fire;
    sample_ch_a <= fire ? val_a : ~sample_ch_a;
    sample_ch_b <= fire ? val_b : ~sample_ch_b;
    junction_temp_in <= fire ? val_t : ~junction_temp_in;
  end
endmodule // asp_adc_model

//--- test/asp_top_test.sv
// Self-checking bench of the angle signal path
module asp_top_test;
  import asp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, reset = 1, fire = 0, reg_wr = 0, reg_rd = 0, slow_take = 0, ce = 1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d, e;
  logic [15:0] va = 16'h0, vb = 16'h0, slow_word, ca, cb, ct;
  logic [11:0] out_code;
  logic        out_valid, mag_fault, slow_valid, sv;
  int          n_mismatch = 0, n_tests = 0, cyc = 0;
  asp_adc_model adc (.clk(clk), .fire(fire), .val_a(va), .val_b(vb),
    .val_t(16'h0123), .sample_valid(sv), .sample_ch_a(ca), .sample_ch_b(cb),
    .junction_temp_in(ct));
  asp_top dut (.clk(clk), .reset(reset), .clk_en(ce), .sample_valid(sv),
    .sample_ch_a(ca), .sample_ch_b(cb), .junction_temp_in(ct), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .out_code(out_code), .out_valid(out_valid), .mag_fault(mag_fault),
    .slow_word(slow_word), .slow_valid(slow_valid), .slow_take(slow_take));
  initial begin
    forever #10 clk = ~clk;
  end
  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim;
    end
  end
  task cmp(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= {16'h0000, v};
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task chk(input logic [7:0] a, input logic [31:0] x);
    rd(a);
    cmp(d, x);
  endtask
  // A second pulse while busy is dropped by the block
  task smp(input logic [15:0] a, input logic twice);
    int i;
    @(posedge clk);
    va <= a;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    if (twice) begin
      repeat (3) @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
    end
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      #1 if (out_valid === 1'b1) break;
    end
    cmp({31'h0, i < 128}, 32'h1);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (30) @(posedge clk);
    chk(8'h11, 32'h1111);
    chk(8'h12, 32'h2222);
    chk(8'h26, 32'hffff);
    chk(8'h10, 32'h0);
    chk(8'h7f, 32'h0);
    wr(8'h11, 16'h0000);
    chk(8'h11, 32'h1111);
    $display("registers test done");
    wr(8'h25, 16'h2328);
    wr(8'h20, 16'h0400);
    wr(8'h1f, 16'h0000);
    wr(8'h59, 16'h1000);
    wr(8'h23, 16'h2000);
    wr(8'h24, 16'h0010);
    smp(16'h4000, 1'b0);
    cmp(out_code, 32'h901);
    cmp(mag_fault, 32'h1);
    chk(8'h00, 32'h0123);
    chk(8'h01, 32'h4000);
    chk(8'h02, 32'h0);
    chk(8'h03, 32'h2000);
    chk(8'h04, 32'h4000);
    chk(8'h06, 32'h0);
    chk(8'h0a, 32'h0400);
    chk(8'h0b, 32'h0800);
    chk(8'h0c, 32'h0800);
    chk(8'h0d, 32'h1010);
    chk(8'h0e, 32'h9010);
    chk(8'h0f, 32'h1);
    wr(8'h0e, 16'h0000);
    chk(8'h0e, 32'h9010);
    $display("path test done");
    wr(8'h1d, 16'h1000);
    wr(8'h1e, 16'h0001);
    wr(8'h25, 16'h0000);
    smp(16'h4000, 1'b0);
    cmp(mag_fault, 32'h0);
    rd(8'h07);
    e = d;
    rd(8'h08);
    cmp(d, (e - 32'h1000) & 32'hffff);
    e = d;
    rd(8'h09);
    cmp(d, (e << 1) & 32'hffff);
    $display("reference test done");
    smp(16'h4000, 1'b1);
    chk(8'h10, 32'h2);
    wr(8'h10, 16'h0002);
    chk(8'h10, 32'h0);
    $display("overrun test done");
    wr(8'h21, 16'h0001);
    wr(8'h20, 16'hc000);
    wr(8'h49, 16'h2000);
    wr(8'h18, 16'h2000);
    wr(8'h27, 16'h0100);
    vb <= 16'h2000;
    smp(16'h4000, 1'b0);
    chk(8'h21, 32'h1);
    chk(8'h0b, 32'h1000);
    chk(8'h01, 32'h4002);
    chk(8'h02, 32'h2002);
    chk(8'h03, 32'h2803);
    chk(8'h05, 32'h1002);
    chk(8'h06, 32'h1002);
    $display("setpoint mode test done");
    wr(8'h21, 16'h0002);
    repeat (3) @(posedge clk);
    #1 cmp({slow_valid, slow_word}, {1'b1, 16'h1111});
    @(posedge clk);
    slow_take <= 1'b1;
    @(posedge clk);
    slow_take <= 1'b0;
    repeat (3) @(posedge clk);
    #1 cmp({slow_valid, slow_word}, {1'b1, 16'h2222});
    // A take while the enable is low must not consume the word
    @(posedge clk);
    ce <= 1'b0;
    slow_take <= 1'b1;
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    slow_take <= 1'b0;
    #1 cmp({slow_valid, slow_word}, {1'b1, 16'h2222});
    $display("slow channel test done");
    end_sim;
  end
endmodule // asp_top_test
